// *** design/stsm_pkg.sv ***
// shared constants and types of the secondary transmit channel 7/8 slot mapper
package stsm_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] STSM_ADDR_CH7 = 8'h24;
	localparam logic [7:0] STSM_ADDR_CH8 = 8'h25;
	localparam logic [7:0] STSM_ADDR_FMT = 8'h28;
	localparam logic [7:0] STSM_RST_CH7  = 8'h06;
	localparam logic [7:0] STSM_RST_CH8  = 8'h07;
	localparam logic [7:0] STSM_RST_FMT  = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int STSM_SRC7_MSB = 6;
	localparam int STSM_SRC7_LSB = 5;
	localparam int STSM_SRC8_BIT = 5;
	localparam int STSM_SLOT_MSB = 4;
	localparam int STSM_SLOT_LSB = 0;
	localparam int STSM_FMT_BIT  = 0;

	// ----------------------------------------------------------------
	// link framing
	// ----------------------------------------------------------------
	localparam int         STSM_SLOT_BITS   = 32;
	localparam logic [4:0] STSM_LAST_BIT    = 5'h1f;
	localparam logic [4:0] STSM_FIRST_BIT   = 5'h00;
	localparam logic [4:0] STSM_LAST_SLOT   = 5'h1f;
	localparam logic [4:0] STSM_LEFT_BASE   = 5'h00;
	localparam logic [4:0] STSM_RIGHT_BASE  = 5'h10;

	typedef enum logic [1:0] {
		STSM_CH7_OFF      = 2'b00,
		STSM_CH7_BAT_TEMP = 2'b01,
		STSM_CH7_ECHO     = 2'b10,
		STSM_CH7_RSVD     = 2'b11
	} stsm_ch7_src_t;

	typedef enum logic {
		STSM_HS_IDLE = 1'b0,
		STSM_HS_WAIT = 1'b1
	} stsm_hs_t;

	typedef struct packed {
		logic          fmt_half;
		stsm_ch7_src_t ch7_src;
		logic [4:0]    ch7_slot;
		logic          ch8_src;
		logic [4:0]    ch8_slot;
	} stsm_cfg_t;

	localparam stsm_cfg_t STSM_CFG_RESET = '{
		fmt_half: STSM_RST_FMT[STSM_FMT_BIT],
		ch7_src:  stsm_ch7_src_t'(STSM_RST_CH7[STSM_SRC7_MSB:STSM_SRC7_LSB]),
		ch7_slot: STSM_RST_CH7[STSM_SLOT_MSB:STSM_SLOT_LSB],
		ch8_src:  STSM_RST_CH8[STSM_SRC8_BIT],
		ch8_slot: STSM_RST_CH8[STSM_SLOT_MSB:STSM_SLOT_LSB]
	};

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} stsm_reg_req_t;

	typedef struct packed {
		logic [15:0] battery_half_word;
		logic [15:0] temperature_half_word;
		logic [15:0] echo_ref_first_half_word;
		logic [15:0] echo_ref_second_half_word;
		logic [31:0] inter_chip_link_data;
	} stsm_samples_t;

endpackage

// *** design/stsm_sync2.sv ***
// two-flop synchroniser for one level, async clear
module stsm_sync2 (
	input  wire logic clk,   // destination clock
	input  wire logic rst_n, // async clear, active low
	input  wire logic d,     // level from another domain
	output logic      q      // synchronised level
);

	logic meta;
	logic next_meta;
	logic next_q;

	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= next_meta;
			q    <= next_q;
		end
	end

endmodule

// *** design/stsm_top.sv ***
// secondary serial port transmit channels 7 and 8: config registers and slot mapper
//
// Notes on behaviour
// - channel 7 source 0 keeps output undriven; value 3 is reserved, treated as off.
// - channel 7 source 1 sends battery half-word then temperature half-word.
// - channel 7 source 2 sends first then second echo reference half-word.
// - channel 8 source bit 5: 0 undriven, 1 sends inter-chip link data.
// - slot field 0..15 means TDM slot n or left-half slot n.
// - slot field 16..31 means TDM slot n or right-half slot n minus 16.
// - channel 7 resets to slot 6, source 0.
// - channel 8 resets to slot 7, source 0.
// - channel 8 bits 7-6 read zero; host writes only zero there.
// - channel 7 bit 7 reads zero; host writes only zero there.
// - channel 7 register sits at 0x24 and resets to 0x06.
module stsm_top
	import stsm_pkg::*;
(
	input  wire logic                    core_clk,     // register clock, 200 MHz
	input  wire logic                    rst_n,        // async reset, active low
	input  wire stsm_pkg::stsm_reg_req_t reg_req,      // address, data, strobes
	output logic [7:0]                   reg_rdata,    // read data, cycle after rd
	input  wire logic                    link_clk,     // serial bit clock
	input  wire logic                    frame_sync,   // frame sync, link domain
	input  wire stsm_pkg::stsm_samples_t samples,      // source words, link domain
	output logic                         sec_sdout,    // secondary data out
	output logic                         sec_sdout_oe  // high while driving
);

	// ----------------------------------------------------------------
	// core domain: registers and config handover
	// ----------------------------------------------------------------
	stsm_cfg_t  cfg;
	stsm_cfg_t  next_cfg;
	stsm_cfg_t  snap;
	stsm_cfg_t  next_snap;
	stsm_hs_t   hs;
	stsm_hs_t   next_hs;
	logic       pending;
	logic       next_pending;
	logic       req_tgl;
	logic       next_req_tgl;
	logic [7:0] next_rdata;
	logic [7:0] rd7_val;
	logic [7:0] rd8_val;
	logic [7:0] rdf_val;
	logic       wr_hit;
	logic       ack_core;
	logic       ack_link;
	logic       init_seen;

	assign rd7_val = {1'b0, cfg.ch7_src, cfg.ch7_slot};
	assign rd8_val = {2'b00, cfg.ch8_src, cfg.ch8_slot};
	assign rdf_val = {7'h00, cfg.fmt_half};

	always_comb begin
		next_cfg     = cfg;
		next_rdata   = 8'h00;
		wr_hit       = 1'b0;
		next_snap    = snap;
		next_hs      = hs;
		next_req_tgl = req_tgl;
		// reserved bits are simply not stored, so they always read zero
		if (reg_req.wr) begin
			case (reg_req.addr)
				STSM_ADDR_CH7: begin
					next_cfg.ch7_src  = stsm_ch7_src_t'(
						reg_req.wdata[STSM_SRC7_MSB:STSM_SRC7_LSB]);
					next_cfg.ch7_slot = reg_req.wdata[STSM_SLOT_MSB:STSM_SLOT_LSB];
					wr_hit            = 1'b1;
				end
				STSM_ADDR_CH8: begin
					next_cfg.ch8_src  = reg_req.wdata[STSM_SRC8_BIT];
					next_cfg.ch8_slot = reg_req.wdata[STSM_SLOT_MSB:STSM_SLOT_LSB];
					wr_hit            = 1'b1;
				end
				STSM_ADDR_FMT: begin
					next_cfg.fmt_half = reg_req.wdata[STSM_FMT_BIT];
					wr_hit            = 1'b1;
				end
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			case (reg_req.addr)
				STSM_ADDR_CH7: next_rdata = rd7_val;
				STSM_ADDR_CH8: next_rdata = rd8_val;
				STSM_ADDR_FMT: next_rdata = rdf_val;
				default:       next_rdata = 8'h00;
			endcase
		end
		// snapshot stays frozen until the link side echoes the toggle back
		next_pending = wr_hit | pending;
		case (hs)
			STSM_HS_IDLE: begin
				if (pending) begin
					next_snap    = cfg;
					next_req_tgl = ~req_tgl;
					next_hs      = STSM_HS_WAIT;
					next_pending = wr_hit;
				end
			end
			STSM_HS_WAIT: begin
				if (ack_core == req_tgl) begin
					next_hs = STSM_HS_IDLE;
				end
			end
			default: next_hs = STSM_HS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg       <= STSM_CFG_RESET;
			snap      <= STSM_CFG_RESET;
			hs        <= STSM_HS_IDLE;
			pending   <= 1'b0;
			req_tgl   <= 1'b0;
			reg_rdata <= 8'h00;
			init_seen <= 1'b0;
		end else begin
			cfg       <= next_cfg;
			snap      <= next_snap;
			hs        <= next_hs;
			pending   <= next_pending;
			req_tgl   <= next_req_tgl;
			reg_rdata <= next_rdata;
			init_seen <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// crossings
	// ----------------------------------------------------------------
	logic link_rst_n;
	logic req_link;

	stsm_sync2 u_link_rst (
		.clk   (link_clk),
		.rst_n (rst_n),
		.d     (1'b1),
		.q     (link_rst_n)
	);

	stsm_sync2 u_req_sync (
		.clk   (link_clk),
		.rst_n (link_rst_n),
		.d     (req_tgl),
		.q     (req_link)
	);

	stsm_sync2 u_ack_sync (
		.clk   (core_clk),
		.rst_n (rst_n),
		.d     (ack_link),
		.q     (ack_core)
	);

	// ----------------------------------------------------------------
	// link domain: slot counting and output
	// ----------------------------------------------------------------
	stsm_cfg_t  lcfg;
	stsm_cfg_t  next_lcfg;
	logic       next_ack_link;
	logic       fsync_q;
	logic       framed;
	logic       next_framed;
	logic [4:0] bit_cnt;
	logic [4:0] slot_cnt;
	logic [4:0] cur_bit;
	logic [4:0] cur_slot;
	logic       start;
	logic       right_start;
	logic       act7;
	logic       hit7;
	logic       hit8;
	logic [31:0] word7;
	logic [31:0] shift;
	logic [31:0] next_shift;
	logic       next_oe;

	always_comb begin
		next_ack_link = req_link;
		next_lcfg     = (req_link != ack_link) ? snap : lcfg;
		start         = frame_sync & ~fsync_q;
		// half-frame formats restart counting at slot 16 on the falling edge
		right_start   = lcfg.fmt_half & ~frame_sync & fsync_q;
		if (start) begin
			cur_bit  = STSM_FIRST_BIT;
			cur_slot = STSM_LEFT_BASE;
		end else if (right_start) begin
			cur_bit  = STSM_FIRST_BIT;
			cur_slot = STSM_RIGHT_BASE;
		end else begin
			cur_bit  = bit_cnt + 5'h01;
			cur_slot = (bit_cnt == STSM_LAST_BIT) ? slot_cnt + 5'h01 : slot_cnt;
		end
		// a frame longer than 32 slots stops driving rather than wrapping
		next_framed = framed;
		if (start || right_start) begin
			next_framed = 1'b1;
		end else if (bit_cnt == STSM_LAST_BIT && slot_cnt == STSM_LAST_SLOT) begin
			next_framed = 1'b0;
		end
		act7 = (lcfg.ch7_src == STSM_CH7_BAT_TEMP) || (lcfg.ch7_src == STSM_CH7_ECHO);
		hit7 = next_framed && act7 && (cur_slot == lcfg.ch7_slot);
		hit8 = next_framed && lcfg.ch8_src && (cur_slot == lcfg.ch8_slot);
		case (lcfg.ch7_src)
			STSM_CH7_BAT_TEMP: word7 = {samples.battery_half_word,
				samples.temperature_half_word};
			STSM_CH7_ECHO:     word7 = {samples.echo_ref_first_half_word,
				samples.echo_ref_second_half_word};
			default:           word7 = 32'h0000_0000;
		endcase
		// channel 7 wins if both are mapped to the same slot
		if (cur_bit == STSM_FIRST_BIT) begin
			next_shift = hit7 ? word7 : (hit8 ? samples.inter_chip_link_data : 32'h0000_0000);
		end else begin
			next_shift = {shift[STSM_SLOT_BITS-2:0], 1'b0};
		end
		next_oe = hit7 | hit8;
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lcfg         <= STSM_CFG_RESET;
			ack_link     <= 1'b0;
			fsync_q      <= 1'b0;
			framed       <= 1'b0;
			bit_cnt      <= STSM_LAST_BIT;
			slot_cnt     <= STSM_LAST_SLOT;
			shift        <= 32'h0000_0000;
			sec_sdout    <= 1'b0;
			sec_sdout_oe <= 1'b0;
		end else begin
			lcfg         <= next_lcfg;
			ack_link     <= next_ack_link;
			fsync_q      <= frame_sync;
			framed       <= next_framed;
			bit_cnt      <= cur_bit;
			slot_cnt     <= cur_slot;
			shift        <= next_shift;
			sec_sdout    <= next_shift[STSM_SLOT_BITS-1];
			sec_sdout_oe <= next_oe;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic bat_msb;
	logic echo_msb;
	logic icl_msb;
	logic first_bit;

	assign bat_msb   = samples.battery_half_word[15];
	assign echo_msb  = samples.echo_ref_first_half_word[15];
	assign icl_msb   = samples.inter_chip_link_data[STSM_SLOT_BITS-1];
	assign first_bit = (cur_bit == STSM_FIRST_BIT);

	property p_all_off;
		@(posedge link_clk) disable iff (!link_rst_n)
		(!act7 && !lcfg.ch8_src) |=> !sec_sdout_oe;
	endproperty
	a_all_off: assert property (p_all_off) else $error("driven while off");

	property p_bat;
		@(posedge link_clk) disable iff (!link_rst_n)
		(hit7 && first_bit && lcfg.ch7_src == STSM_CH7_BAT_TEMP)
			|=> sec_sdout_oe && (sec_sdout == $past(bat_msb));
	endproperty
	a_bat: assert property (p_bat) else $error("battery msb wrong");

	property p_echo;
		@(posedge link_clk) disable iff (!link_rst_n)
		(hit7 && first_bit && lcfg.ch7_src == STSM_CH7_ECHO)
			|=> sec_sdout_oe && (sec_sdout == $past(echo_msb));
	endproperty
	a_echo: assert property (p_echo) else $error("echo msb wrong");

	property p_icl;
		@(posedge link_clk) disable iff (!link_rst_n)
		(hit8 && !hit7 && first_bit) |=> sec_sdout_oe && (sec_sdout == $past(icl_msb));
	endproperty
	a_icl: assert property (p_icl) else $error("link data msb wrong");

	property p_left_slot;
		@(posedge link_clk) disable iff (!link_rst_n)
		(start && act7 && lcfg.ch7_slot == STSM_LEFT_BASE) |=> sec_sdout_oe [*8];
	endproperty
	a_left_slot: assert property (p_left_slot) else $error("slot 0 not driven");

	property p_right_slot;
		@(posedge link_clk) disable iff (!link_rst_n)
		(right_start && act7 && lcfg.ch7_slot == STSM_RIGHT_BASE) |=> sec_sdout_oe;
	endproperty
	a_right_slot: assert property (p_right_slot) else $error("right slot 0 missed");

	property p_gap;
		@(posedge link_clk) disable iff (!link_rst_n)
		!(hit7 || hit8) |=> !sec_sdout_oe;
	endproperty
	a_gap: assert property (p_gap) else $error("driven outside slot");

	property p_reset_vals;
		@(posedge core_clk) disable iff (!rst_n)
		!init_seen |-> (rd7_val == STSM_RST_CH7) && (rd8_val == STSM_RST_CH8);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_rd7;
		@(posedge core_clk) disable iff (!rst_n)
		(reg_req.rd && reg_req.addr == STSM_ADDR_CH7)
			|=> (reg_rdata == $past(rd7_val)) && !reg_rdata[7];
	endproperty
	a_rd7: assert property (p_rd7) else $error("ch7 read wrong");

	property p_rd8;
		@(posedge core_clk) disable iff (!rst_n)
		(reg_req.rd && reg_req.addr == STSM_ADDR_CH8)
			|=> (reg_rdata == $past(rd8_val)) && (reg_rdata[7:6] == 2'b00);
	endproperty
	a_rd8: assert property (p_rd8) else $error("ch8 read wrong");

	c_ch7_drive: cover property (@(posedge link_clk) disable iff (!link_rst_n)
		hit7 ##1 sec_sdout_oe);
	c_ch8_drive: cover property (@(posedge link_clk) disable iff (!link_rst_n)
		hit8 && !hit7 ##1 sec_sdout_oe);
	c_right: cover property (@(posedge link_clk) disable iff (!link_rst_n) right_start);
	c_handover: cover property (@(posedge core_clk) disable iff (!rst_n)
		hs == STSM_HS_WAIT ##1 hs == STSM_HS_IDLE);

endmodule

// *** test/stsm_host_model.sv ***
// host-side receiver model: drives frame sync and collects the secondary data slots
module stsm_host_model (
	input  wire logic  link_clk,       // serial bit clock
	input  wire logic  rst_n,          // async reset, active low
	input  wire logic  start,          // request one frame, level
	input  wire logic  half_mode,      // 1: sync high for the left half only
	input  wire logic  sdout,          // data from the device
	input  wire logic  sdout_oe,       // device drive enable
	output logic       frame_sync,     // frame sync to the device
	output logic       busy,           // frame in progress
	output logic [31:0] slot_word [32], // word captured per slot
	output logic [5:0] slot_on [32],   // driven bits per slot
	output logic [5:0] overrun         // driven bits after slot 31
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [10:0] cnt;
	logic [10:0] bit_idx;
	logic        line;
	logic        line_last = 1'b0;

	// ----------------------------------------------------------------
	// frame generation
	// ----------------------------------------------------------------
	// no pull on the line: an undriven line reads as the inverse of its last level
	assign line    = sdout_oe ? sdout : ~line_last;
	assign bit_idx = cnt - 11'h001;

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_sync <= 1'b0;
			busy       <= 1'b0;
			cnt        <= 11'h000;
		end else if (!busy) begin
			if (start) begin
				busy       <= 1'b1;
				frame_sync <= 1'b1;
				cnt        <= 11'h000;
			end
		end else begin
			cnt <= cnt + 11'h001;
			if ((!half_mode && cnt == 11'h000) || (half_mode && cnt == 11'h1ff))
				frame_sync <= 1'b0;
			if (cnt == 11'h402)
				busy <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// capture on the falling edge, mid-bit
	// ----------------------------------------------------------------
	always @(negedge link_clk) begin
		if (busy && cnt == 11'h000) begin
			for (int i = 0; i < 32; i++) begin
				slot_word[i] = 32'h0;
				slot_on[i]   = 6'h00;
			end
			overrun = 6'h00;
		end else if (busy && cnt <= 11'h402) begin
			if (bit_idx >= 11'h400) begin
				overrun = overrun + 6'(sdout_oe);
			end else begin
				slot_word[bit_idx[9:5]] = {slot_word[bit_idx[9:5]][30:0], line};
				slot_on[bit_idx[9:5]]   = slot_on[bit_idx[9:5]] + 6'(sdout_oe);
			end
		end
		line_last = line;
	end
endmodule

// *** test/stsm_top_tb.sv ***
// self-checking bench of the channel 7/8 slot mapper
module stsm_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import stsm_pkg::*;

	logic          core_clk  = 1'b0;
	logic          link_clk  = 1'b0;
	logic          rst_n     = 1'b0;
	logic          start     = 1'b0;
	logic          half_mode = 1'b0;
	stsm_reg_req_t reg_req   = '0;
	stsm_samples_t samples   = '0;
	logic [7:0]    reg_rdata;
	logic          frame_sync;
	logic          sec_sdout;
	logic          sec_sdout_oe;
	logic          busy;
	logic [31:0]   slot_word [32];
	logic [5:0]    slot_on [32];
	logic [5:0]    overrun;
	logic [1:0]    src7;
	logic [4:0]    slot7;
	logic          src8;
	logic [4:0]    slot8;
	int            n_mismatch = 0;
	int            tests_run  = 0;

	always #2.5 core_clk = ~core_clk;
	always #6 link_clk = ~link_clk;

	stsm_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .link_clk(link_clk), .frame_sync(frame_sync),
		.samples(samples), .sec_sdout(sec_sdout), .sec_sdout_oe(sec_sdout_oe));

	stsm_host_model i_host (.link_clk(link_clk), .rst_n(rst_n), .start(start),
		.half_mode(half_mode), .sdout(sec_sdout), .sdout_oe(sec_sdout_oe),
		.frame_sync(frame_sync), .busy(busy), .slot_word(slot_word),
		.slot_on(slot_on), .overrun(overrun));

	// ----------------------------------------------------------------
	// checking and expectations
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic exp_on(input int s);
		return (s == slot7 && (src7 == 2'd1 || src7 == 2'd2)) || (s == slot8 && src8);
	endfunction

	// channel 7 is checked first: it wins a shared slot
	function automatic logic [31:0] exp_word(input int s);
		if (s == slot7 && src7 == 2'd1)
			return {samples.battery_half_word, samples.temperature_half_word};
		if (s == slot7 && src7 == 2'd2)
			return {samples.echo_ref_first_half_word, samples.echo_ref_second_half_word};
		return samples.inter_chip_link_data;
	endfunction

	// ----------------------------------------------------------------
	// bus and frame tasks
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		reg_req.wr <= 1'b0;
	endtask

	task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
		#1;
		check("reg_rdata", {24'h0, reg_rdata}, {24'h0, e});
	endtask

	task automatic run_frame();
		int n;
		@(posedge link_clk);
		samples <= {$urandom, $urandom, $urandom};
		start   <= 1'b1;
		@(posedge link_clk);
		start <= 1'b0;
		#1;
		for (n = 0; n < 1100 && busy !== 1'b0; n++)
			@(posedge link_clk);
		if (n == 1100) begin
			n_mismatch++;
			$display("Error frame_done expected 0 seen 1");
			conclude();
		end
		for (int s = 0; s < 32; s++) begin
			check("slot_on", 32'(slot_on[s]), exp_on(s) ? 32'd32 : 32'd0);
			if (exp_on(s))
				check("slot_word", slot_word[s], exp_word(s));
		end
		check("overrun", 32'(overrun), 32'h0);
	endtask

	task automatic set_cfg(input logic [1:0] s7, input logic [4:0] n7, input logic s8,
		input logic [4:0] n8, input logic h);
		src7  = s7;
		slot7 = n7;
		src8  = s8;
		slot8 = n8;
		reg_wr(8'h24, {1'b0, s7, n7});
		reg_wr(8'h25, {2'b00, s8, n8});
		reg_wr(8'h28, {7'h00, h});
		reg_chk(8'h24, {1'b0, s7, n7});
		reg_chk(8'h25, {2'b00, s8, n8});
		half_mode <= h;
		// config crosses to the link side through a handshake: allow 1 us
		repeat (200) @(posedge core_clk);
		run_frame();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(40734));
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		reg_chk(8'h24, 8'h06);
		@(posedge core_clk);
		#1;
		check("rdata_idle", {24'h0, reg_rdata}, 32'h0);
		reg_chk(8'h25, 8'h07);
		reg_chk(8'h28, 8'h00);
		src7  = 2'd0;
		slot7 = 5'd6;
		src8  = 1'b0;
		slot8 = 5'd7;
		repeat (10) @(posedge link_clk);
		run_frame();
		// the host keeps reserved bits at zero on write; they must still read back zero
		reg_wr(8'h24, 8'h7f);
		reg_chk(8'h24, 8'h7f);
		reg_wr(8'h25, 8'h3f);
		reg_chk(8'h25, 8'h3f);
		reg_wr(8'h30, 8'h5a);
		reg_chk(8'h30, 8'h00);
		set_cfg(2'd1, 5'd0, 1'b1, 5'd31, 1'b0);
		// channel 7 live on right slot 0 in half-frame mode reaches the right-start check
		set_cfg(2'd2, 5'd16, 1'b1, 5'd15, 1'b1);
		set_cfg(2'd3, 5'd15, 1'b1, 5'd16, 1'b1);
		set_cfg(2'd1, 5'd9, 1'b1, 5'd9, 1'b0);
		set_cfg(2'd0, 5'd31, 1'b0, 5'd0, 1'b0);
		repeat (6)
			set_cfg(2'($urandom), 5'($urandom), 1'($urandom), 5'($urandom), 1'($urandom));
		conclude();
	end
endmodule
